/* File: logic/xccd_pkg.sv */
// Purpose: shared constants and types for the channel clock distribution block
// Assumes: one system clock, synchronous active-high reset
// Notes:   clocks are modelled as single-cycle enable ticks derived from sys_clk
package xccd_pkg;

    // ------------------------------------------------------------
    // figures
    // ------------------------------------------------------------
    localparam int unsigned LANE_COUNT     = 4;       // channels per block
    localparam int unsigned LINE_RATE_MBPS = 2500;    // bonded lane rate
    localparam int unsigned SERIAL_MHZ     = LINE_RATE_MBPS / 2;  // half the line rate
    localparam int unsigned PAR_MHZ        = 250;     // central parallel clock
    localparam int unsigned FABRIC_MHZ     = PAR_MHZ / 2;
    localparam int unsigned SER_TO_PAR_DIV = SERIAL_MHZ / PAR_MHZ; // ticks per parallel
    localparam int unsigned SYMBOL_BITS    = 10;      // serializer input width
    localparam int unsigned FIFO_DEPTH_LOG = 2;       // phase fifo address bits
    localparam int unsigned RESET_PTR      = 0;

    // ------------------------------------------------------------
    // mode
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        XCCD_SINGLE_RM,
        XCCD_SINGLE_NORM,
        XCCD_BOND_RM,
        XCCD_BOND_NORM
    } xccd_mode_t;

    // per-lane clock enables handed to the datapath
    typedef struct packed
    {
        logic deserOut;      // deserializer output, aligner
        logic rateWrite;     // rate matcher write side
        logic rateRead;      // rate matcher read side
        logic decoder;       // 10b decoder and byte deser write side
        logic rxFifoWrite;   // receive phase fifo device side
        logic rxFifoRead;    // receive phase fifo fabric side
        logic txFifoWrite;   // transmit phase fifo fabric side
        logic txFifoRead;    // transmit phase fifo device side
        logic encoder;       // encoder, byte serializer read, serializer load
        logic shift;         // serial shift out
    } xccd_lane_clk_t;

endpackage

/* File: logic/xccd_phase_fifo.sv */
// Purpose: phase compensation fifo between two frequency-locked tick domains
// Assumes: both ticks derived from sys_clk; rates are equal on average
// Notes:   gray pointers keep the occupancy compare glitch free
`timescale 1ns/10ps
module xccd_phase_fifo
    import xccd_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned ALOG  = FIFO_DEPTH_LOG
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // write side
    input  wire logic             wrTick,
    input  wire logic [WIDTH-1:0] wrData,
    // read side
    input  wire logic             rdTick,
    output logic      [WIDTH-1:0] rdData,
    output logic                  rdValid,
    output logic                  overflow
);

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem [2**ALOG];
    logic [ALOG:0]    wrPtr;
    logic [ALOG:0]    rdPtr;
    logic [ALOG:0]    wrGray;
    logic [ALOG:0]    rdGray;
    logic             isEmpty;
    logic             isFull;

    assign wrGray  = wrPtr ^ (wrPtr >> 1);
    assign rdGray  = rdPtr ^ (rdPtr >> 1);
    assign isEmpty = (wrGray == rdGray);
    assign isFull  = (wrGray == {~rdGray[ALOG:ALOG-1], rdGray[ALOG-2:0]});

    // write side; a write into a full fifo is dropped and flagged
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            wrPtr    <= (ALOG+1)'(RESET_PTR);
            overflow <= 1'b0;
        end
        else if (wrTick)
        begin
            if (isFull)
                overflow <= 1'b1;
            else
            begin
                mem[wrPtr[ALOG-1:0]] <= wrData;
                wrPtr                <= wrPtr + 1'b1;
            end
        end
    end

    // read side absorbs phase between the two ticks
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rdPtr   <= (ALOG+1)'(RESET_PTR);
            rdData  <= '0;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= rdTick && !isEmpty;
            if (rdTick && !isEmpty)
            begin
                rdData <= mem[rdPtr[ALOG-1:0]];
                rdPtr  <= rdPtr + 1'b1;
            end
        end
    end

endmodule

/* File: logic/xccd_clock_dist.sv */
// Purpose: clock distribution and default fabric clock selection for four lanes
// Assumes: serial and recovered clocks appear as sys_clk-synchronous ticks
// Notes:   every derived clock is a one-cycle enable, so all logic stays on sys_clk
`timescale 1ns/10ps

// Behaviour
// - recovered clock feeds aligner and rate-matcher write
// - single rate matcher reads on local divider
// - single rate-match decoder runs on local divider clock
// - single rate-match rx fifo write is tx fabric clock
// - single rate-match rx fifo read defaults to lane 0 clock
// - bonded lanes share one tx clock set
// - serial clock is half the line rate
// - central divider makes the parallel clock
// - bonded fabric clock is half parallel
// - bonded tx fifo: half read, default write
// - encoder on parallel, shift on serial clock
// - bonded no-match rx runs on recovered clocks
// - bonded rx fifo read defaults to fabric clock
// - bonded matchers write recovered, read central
// - bonded rate-match decoder parallel, fifo half parallel
// - lane 0 clock drives all fifo fabric ports in single rate-match mode
// - single no-match: lane 0 tx, own rx half
// - each lane has tx and rx fifos
// - single no-match: output half recovered clock
module xccd_clock_dist
    import xccd_pkg::*;
#(
    parameter int unsigned LANES = LANE_COUNT,
    parameter int unsigned DW    = 16
)
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    // configuration
    input  wire xccd_mode_t            mode,
    input  wire logic                  byteSerUsed,
    input  wire logic                  userTxClkEn,
    input  wire logic [LANES-1:0]      userTxClkTick,
    input  wire logic                  userRxClkEn,
    input  wire logic [LANES-1:0]      userRxClkTick,
    // link side ticks
    input  wire logic                  serialTick,
    input  wire logic [LANES-1:0]      recoveredTick,
    // datapath
    input  wire logic [LANES*DW-1:0]   txFabricData,
    output logic      [LANES*DW-1:0]   txPcsData,
    output logic      [LANES-1:0]      txPcsValid,
    input  wire logic [LANES*DW-1:0]   rxPcsData,
    output logic      [LANES*DW-1:0]   rxFabricData,
    output logic      [LANES-1:0]      rxFabricValid,
    output logic      [2*LANES-1:0]    fifoOverflow,
    // clocks out, as ticks
    output xccd_lane_clk_t [LANES-1:0] laneClk,
    output logic      [LANES-1:0]      txFabricClockOut,
    output logic      [LANES-1:0]      rxRecoveredHalfClock,
    output logic                       bondedFabricClock,
    output logic                       parallelClock
);

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    localparam int unsigned DCW = $clog2(SER_TO_PAR_DIV + 1);

    logic             bonded;
    logic             rateMatch;
    logic [DCW-1:0]   centralCount;
    logic             centralPar;
    logic             centralHalf;
    logic             halfPhase;
    logic [LANES-1:0] localPar;
    logic [LANES-1:0] localHalf;
    logic [LANES-1:0] recHalfPhase;
    logic [LANES-1:0] recHalf;
    logic [LANES-1:0] locHalfPhase;
    logic [DCW-1:0]   localCount [LANES];

    assign bonded    = (mode == XCCD_BOND_RM) || (mode == XCCD_BOND_NORM);
    assign rateMatch = (mode == XCCD_BOND_RM) || (mode == XCCD_SINGLE_RM);

    // central divider: serial clock at half line rate down to parallel
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            centralCount <= '0;
        else if (serialTick)
            centralCount <= (centralCount == DCW'(SER_TO_PAR_DIV - 1))
                          ? '0 : centralCount + 1'b1;
    end
    assign centralPar = serialTick && (centralCount == DCW'(SER_TO_PAR_DIV - 1));

    // half-rate fabric clock from the central parallel clock
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            halfPhase <= 1'b0;
        else if (centralPar)
            halfPhase <= ~halfPhase;
    end
    assign centralHalf = centralPar && halfPhase;

    // per-lane local dividers, idle in bonded mode, and recovered halvers, which run in every mode
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < LANES; i++)
                localCount[i] <= '0;
            locHalfPhase <= '0;
            recHalfPhase <= '0;
        end
        else
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (serialTick && !bonded)
                    localCount[i] <= (localCount[i] == DCW'(SER_TO_PAR_DIV - 1))
                                   ? '0 : localCount[i] + 1'b1;
                if (localPar[i])
                    locHalfPhase[i] <= ~locHalfPhase[i];
                if (recoveredTick[i])
                    recHalfPhase[i] <= ~recHalfPhase[i];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < LANES; i++)
        begin
            localPar[i]  = !bonded && serialTick
                         && (localCount[i] == DCW'(SER_TO_PAR_DIV - 1));
            localHalf[i] = localPar[i] && locHalfPhase[i];
            recHalf[i]   = recoveredTick[i] && recHalfPhase[i];
        end
    end

    assign parallelClock     = centralPar;
    assign bondedFabricClock = bonded && centralHalf;

    // ------------------------------------------------------------
    // per-lane clock selection
    // ------------------------------------------------------------
    logic [LANES-1:0] txOut;

    // fabric clock out per lane: byte serializer halves the local clock
    always_comb
    begin
        for (int i = 0; i < LANES; i++)
            txOut[i] = byteSerUsed ? localHalf[i] : localPar[i];
    end
    assign txFabricClockOut     = bonded ? '0 : txOut;
    assign rxRecoveredHalfClock = (mode == XCCD_SINGLE_NORM) ? recHalf : '0;

    // one selection per lane; bonded lanes all take the central tx set
    always_comb
    begin
        for (int i = 0; i < LANES; i++)
        begin
            laneClk[i]          = '0;
            laneClk[i].shift    = serialTick;
            laneClk[i].deserOut = recoveredTick[i];
            case (mode)
                XCCD_SINGLE_RM:
                begin
                    laneClk[i].rateWrite   = recoveredTick[i];
                    laneClk[i].rateRead    = localPar[i];
                    laneClk[i].decoder     = localPar[i];
                    laneClk[i].rxFifoWrite = txOut[i];
                    laneClk[i].rxFifoRead  = txOut[0];
                    laneClk[i].txFifoWrite = txOut[0];
                    laneClk[i].txFifoRead  = txOut[i];
                    laneClk[i].encoder     = localPar[i];
                end
                XCCD_SINGLE_NORM:
                begin
                    laneClk[i].decoder     = recoveredTick[i];
                    laneClk[i].rxFifoWrite = recHalf[i];
                    laneClk[i].rxFifoRead  = recHalf[i];
                    laneClk[i].txFifoWrite = txOut[0];
                    laneClk[i].txFifoRead  = txOut[i];
                    laneClk[i].encoder     = localPar[i];
                end
                XCCD_BOND_RM:
                begin
                    laneClk[i].rateWrite   = recoveredTick[i];
                    laneClk[i].rateRead    = centralPar;
                    laneClk[i].decoder     = centralPar;
                    laneClk[i].rxFifoWrite = centralHalf;
                    laneClk[i].rxFifoRead  = centralHalf;
                    laneClk[i].txFifoWrite = centralHalf;
                    laneClk[i].txFifoRead  = centralHalf;
                    laneClk[i].encoder     = centralPar;
                end
                default:
                begin
                    laneClk[i].decoder     = recoveredTick[i];
                    laneClk[i].rxFifoWrite = recHalf[i];
                    laneClk[i].rxFifoRead  = centralHalf;
                    laneClk[i].txFifoWrite = centralHalf;
                    laneClk[i].txFifoRead  = centralHalf;
                    laneClk[i].encoder     = centralPar;
                end
            endcase
            // a user clock overrides the default fabric-side selection;
            // it must be frequency locked to the device clock
            if (userTxClkEn)
                laneClk[i].txFifoWrite = userTxClkTick[i];
            if (userRxClkEn)
                laneClk[i].rxFifoRead = userRxClkTick[i];
        end
    end

    // ------------------------------------------------------------
    // phase compensation fifos, one pair per lane
    // ------------------------------------------------------------
    // a fifo per direction per lane keeps lanes independent
    for (genvar g = 0; g < LANES; g++)
    begin : gLane
        xccd_phase_fifo #(.WIDTH(DW), .ALOG(FIFO_DEPTH_LOG)) uTx
        (
            .sys_clk  (sys_clk),
            .srst     (srst),
            .wrTick   (laneClk[g].txFifoWrite),
            .wrData   (txFabricData[g*DW +: DW]),
            .rdTick   (laneClk[g].txFifoRead),
            .rdData   (txPcsData[g*DW +: DW]),
            .rdValid  (txPcsValid[g]),
            .overflow (fifoOverflow[2*g])
        );
        xccd_phase_fifo #(.WIDTH(DW), .ALOG(FIFO_DEPTH_LOG)) uRx
        (
            .sys_clk  (sys_clk),
            .srst     (srst),
            .wrTick   (laneClk[g].rxFifoWrite),
            .wrData   (rxPcsData[g*DW +: DW]),
            .rdTick   (laneClk[g].rxFifoRead),
            .rdData   (rxFabricData[g*DW +: DW]),
            .rdValid  (rxFabricValid[g]),
            .overflow (fifoOverflow[2*g+1])
        );
    end

endmodule

/* File: verif/xccd_clock_dist_monitor.sv */
// Purpose: port checker for the clock distribution block
// Assumes: every clock is a one-cycle tick on sys_clk
// Notes:   per-lane checks sit in a generate loop
`timescale 1ns/10ps
module xccd_clock_dist_monitor
    import xccd_pkg::*;
#(
    parameter int unsigned LANES = LANE_COUNT
)
(
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       srst,
    // configuration and link ticks
    input wire xccd_mode_t                 mode,
    input wire logic                       userTxClkEn,
    input wire logic [LANES-1:0]           userTxClkTick,
    input wire logic                       userRxClkEn,
    input wire logic                       serialTick,
    input wire logic [LANES-1:0]           recoveredTick,
    // clocks out and status
    input wire xccd_lane_clk_t [LANES-1:0] laneClk,
    input wire logic [LANES-1:0]           txFabricClockOut,
    input wire logic [LANES-1:0]           rxRecoveredHalfClock,
    input wire logic                       bondedFabricClock,
    input wire logic                       parallelClock,
    input wire logic [2*LANES-1:0]         fifoOverflow
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic       bnd;
    logic [2:0] serCnt;
    assign bnd = (mode == XCCD_BOND_RM) || (mode == XCCD_BOND_NORM);
    // serial ticks since the last parallel tick, an independent divide by five
    always_ff @(posedge sys_clk)
    begin
        if (srst || (serialTick && parallelClock))
            serCnt <= 3'h0;
        else if (serialTick)
            serCnt <= serCnt + 3'h1;
    end
    AST_PAR_DIV: assert property (parallelClock == (serialTick && serCnt == 3'h4))
        else $error("parallel tick not every fifth serial tick");
    AST_BOND_HALF: assert property (bondedFabricClock |-> bnd && parallelClock)
        else $error("fabric tick outside a bonded parallel tick");
    AST_BOND_TXOUT: assert property (bnd |-> txFabricClockOut == '0)
        else $error("lane fabric clock out in bonded mode");
    AST_RX_HALF: assert property (rxRecoveredHalfClock != '0 |->
        mode == XCCD_SINGLE_NORM && (rxRecoveredHalfClock & ~recoveredTick) == '0)
        else $error("recovered half tick out of place");
    // lane checks: fabric-facing defaults and shared bonded clocks
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        AST_SHARED: assert property (bnd |-> laneClk[i].encoder == parallelClock
            && laneClk[i].shift == serialTick && laneClk[i].txFifoRead == bondedFabricClock)
            else $error("bonded lane off the shared clocks");
        AST_RM_WRITE: assert property (mode inside {XCCD_SINGLE_RM, XCCD_BOND_RM}
            |-> laneClk[i].rateWrite == recoveredTick[i] && laneClk[i].deserOut == recoveredTick[i])
            else $error("rate matcher write not on recovered tick");
        // local and central dividers share the serial tick and the reset, so they agree
        AST_SRM_LOCAL: assert property (mode == XCCD_SINGLE_RM |->
            laneClk[i].rateRead == parallelClock && laneClk[i].decoder == parallelClock)
            else $error("single matcher read or decoder off local parallel tick");
        AST_BOND_RMRD: assert property (mode == XCCD_BOND_RM |->
            laneClk[i].rateRead == parallelClock && laneClk[i].decoder == parallelClock
            && laneClk[i].rxFifoWrite == bondedFabricClock)
            else $error("bonded matcher read or decoder off parallel tick");
        AST_BOND_NORM: assert property (mode == XCCD_BOND_NORM |->
            laneClk[i].decoder == recoveredTick[i]
            && (recoveredTick[i] || !laneClk[i].rxFifoWrite))
            else $error("bonded decoder off recovered tick");
        AST_BOND_FIFO: assert property (bnd && !userTxClkEn && !userRxClkEn |->
            laneClk[i].txFifoWrite == bondedFabricClock
            && laneClk[i].rxFifoRead == bondedFabricClock)
            else $error("bonded fifo fabric side off default clock");
        AST_SINGLE_TXWR: assert property (!bnd && !userTxClkEn |->
            laneClk[i].txFifoWrite == txFabricClockOut[0])
            else $error("single tx fifo write not on lane zero clock");
        AST_SRM_FIFO: assert property (mode == XCCD_SINGLE_RM && !userRxClkEn |->
            laneClk[i].rxFifoRead == txFabricClockOut[0]
            && laneClk[i].rxFifoWrite == txFabricClockOut[i])
            else $error("rate matched rx fifo clocks wrong");
        AST_NORM_RXRD: assert property (mode == XCCD_SINGLE_NORM && !userRxClkEn |->
            laneClk[i].rxFifoRead == rxRecoveredHalfClock[i])
            else $error("rx fifo read not on own half tick");
        AST_USER_TX: assert property (userTxClkEn |->
            laneClk[i].txFifoWrite == userTxClkTick[i])
            else $error("user tx clock not selected");
        AST_STICKY: assert property (fifoOverflow[2*i] |=> fifoOverflow[2*i])
            else $error("tx overflow flag dropped");
        AST_STICKY_RX: assert property (fifoOverflow[2*i+1] |=> fifoOverflow[2*i+1])
            else $error("rx overflow flag dropped");
    end
endmodule

/* File: verif/xccd_fabric_model.sv */
// Purpose: fabric side stand-in that writes tx words and reads rx words
// Assumes: default fabric clocks are reused, so user clocks stay locked
// Notes:   flood and stall break the locking on purpose
`timescale 1ns/10ps
module xccd_fabric_model
    import xccd_pkg::*;
#(
    parameter int unsigned LANES = LANE_COUNT
)
(
    // clock, reset and misuse controls
    input wire logic                       sys_clk,
    input wire logic                       srst,
    input wire logic                       flood,
    input wire logic                       stall,
    // clocks from the block
    input wire xccd_lane_clk_t [LANES-1:0] laneClk,
    input wire logic [LANES-1:0]           txFabricClockOut,
    input wire logic                       bondedFabricClock,
    // towards the block
    output logic [LANES-1:0]               userTxClkTick,
    output logic [LANES-1:0]               userRxClkTick,
    output logic [LANES*16-1:0]            txFabricData
);
    logic [LANES-1:0][7:0] seq;
    // copying the block's clock is the only way to stay frequency locked
    assign userTxClkTick = flood ? '1 : {LANES{bondedFabricClock | txFabricClockOut[0]}};
    assign userRxClkTick = stall ? '0 : {LANES{bondedFabricClock | txFabricClockOut[0]}};
    // fresh word per write tick: lane number high, running count low
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        assign txFabricData[i*16 +: 16] = {8'(i), seq[i]};
        always_ff @(posedge sys_clk)
        begin
            if (srst)
                seq[i] <= 8'h00;
            else if (laneClk[i].txFifoWrite)
                seq[i] <= seq[i] + 8'h01;
        end
    end
endmodule

/* File: verif/xccd_clock_dist_tb.sv */
// Purpose: self-checking bench for the clock distribution block
// Assumes: serial tick every second cycle, recovered ticks every tenth
// Notes:   ticks are counted on the falling edge, clear of updates
`timescale 1ns/10ps
module xccd_clock_dist_tb;
    import xccd_pkg::*;
    localparam int unsigned L = 4;
    logic                   sys_clk, srst, byteSerUsed, userTxClkEn, userRxClkEn;
    logic                   serialTick, run, flood, stall, bondedFabricClock, parallelClock;
    logic [L-1:0]           userTxClkTick, userRxClkTick, recoveredTick, txPcsValid;
    logic [L-1:0]           txFabricClockOut, rxRecoveredHalfClock, rxFabricValid;
    logic [L*16-1:0]        txFabricData, txPcsData, rxPcsData, rxFabricData;
    logic [2*L-1:0]         fifoOverflow;
    xccd_lane_clk_t [L-1:0] laneClk;
    xccd_mode_t             mode;
    int                     error_cnt, tests_run, cyc, nSer, nRec, nPar, nBond, nTx, nRx;
    xccd_clock_dist #(.LANES(L), .DW(16)) DUT (.sys_clk, .srst, .mode, .byteSerUsed,
        .userTxClkEn, .userTxClkTick, .userRxClkEn, .userRxClkTick, .serialTick,
        .recoveredTick, .txFabricData, .txPcsData, .txPcsValid, .rxPcsData, .rxFabricData,
        .rxFabricValid, .fifoOverflow, .laneClk, .txFabricClockOut, .rxRecoveredHalfClock,
        .bondedFabricClock, .parallelClock);
    xccd_fabric_model #(.LANES(L)) u_fab (.sys_clk, .srst, .flood, .stall, .laneClk,
        .txFabricClockOut, .bondedFabricClock, .userTxClkTick, .userRxClkTick, .txFabricData);
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // link ticks: recovered lanes staggered so they never share a cycle
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        serialTick <= run && cyc[0];
        for (int i = 0; i < L; i++)
            recoveredTick[i] <= run && (cyc % 10 == 2 * i + 1);
    end
    always @(negedge sys_clk)
    begin
        if (!srst)
        begin
            nSer += serialTick;
            nRec += recoveredTick[0];
            nPar += parallelClock;
            nBond += bondedFabricClock;
            nTx += txFabricClockOut[0];
            nRx += rxRecoveredHalfClock[0];
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // reset held three cycles, tick counters cleared for the next window
    task automatic restart(input xccd_mode_t m, input logic bs);
        @(posedge sys_clk);
        {srst, run, flood, stall, userTxClkEn, userRxClkEn} <= 6'h20;
        mode <= m;
        byteSerUsed <= bs;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        run <= 1'b1;
        {nSer, nRec, nPar, nBond, nTx, nRx} = '0;
    endtask
    task automatic await(input bit tx, input int ln);
        int n;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while ((tx ? txPcsValid[ln] : rxFabricValid[ln]) !== 1'b1 && n < 300);
        if ((tx ? txPcsValid[ln] : rxFabricValid[ln]) !== 1'b1)
        begin
            error_cnt++;
            $display("[FAIL] %0t wait for valid ran out", $time);
            conclude();
        end
    endtask
    // every mode with and without the byte serializer: divider ratios
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
            for (int bs = 0; bs < 2; bs++)
            begin
                restart(xccd_mode_t'(m), bs[0]);
                repeat (100) @(posedge sys_clk);
                check(16'(nPar), 16'(nSer / 5));
                check(16'(nBond), 16'(m >= 2 ? nPar / 2 : 0));
                check(16'(nTx), 16'(m >= 2 ? 0 : (bs ? nPar / 2 : nPar)));
                check(16'(nRx), 16'(m == 1 ? nRec / 2 : 0));
            end
    endtask
    // bonded words cross both phase fifos on default clocks
    task automatic t_data();
        restart(XCCD_BOND_NORM, 1'b1);
        rxPcsData <= 64'hA3A3_A2A2_A1A1_A0A0;
        await(1'b1, 3);
        check(txPcsData[63:48], 16'h0300);
        await(1'b0, 2);
        check(rxFabricData[47:32], 16'hA2A2);
    endtask
    // unlocked user clocks overrun the fifos; flags must stick
    task automatic t_overflow();
        restart(XCCD_BOND_RM, 1'b1);
        userTxClkEn <= 1'b1;
        flood <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check(16'(fifoOverflow), 16'h0055);
        userRxClkEn <= 1'b1;
        stall <= 1'b1;
        repeat (150) @(posedge sys_clk);
        {flood, stall} <= 2'h0;
        repeat (30) @(posedge sys_clk);
        check(16'(fifoOverflow), 16'h00FF);
    endtask
    initial
    begin
        {srst, run, flood, stall, userTxClkEn, userRxClkEn, byteSerUsed, serialTick} = 8'h80;
        mode = XCCD_SINGLE_RM;
        recoveredTick = '0;
        rxPcsData = '0;
        {error_cnt, tests_run, cyc} = '0;
        t_modes();
        t_data();
        t_overflow();
        conclude();
    end
endmodule
bind xccd_clock_dist xccd_clock_dist_monitor #(.LANES(LANES)) u_mon (.sys_clk, .srst, .mode,
    .userTxClkEn, .userTxClkTick, .userRxClkEn, .serialTick, .recoveredTick, .laneClk,
    .txFabricClockOut, .rxRecoveredHalfClock, .bondedFabricClock, .parallelClock,
    .fifoOverflow);
